// ===== rtl/pflc_pkg.sv
/*
 * Package for the power-fail lock-out controller: timing constants,
 * the lock-out state encoding and the grouped status carrier.
 * Assumes a 25 MHz system clock.
 */
// What this block does
// - Low power input debounced 30 to 31 us
// - Debounce expiry raises power-failing and interrupt
// - Strobe held over 30 us forces lock-out
// - Delay option keeps bus open 480 us
// - Clearing delay enable locks out at once
// - Locked out: ignore bus, float data; on battery, int pins open drain
// - Mode bit keeps interrupts running after failure
// - Unlock only after high input debounced
// - Masked interrupt: sensing off, lock-out still works
// - Battery standby switches power-fail sensing off
// - Power-up sets oscillator-fail, clears start bit
// - Oscillator-fail holds until clock is started
// - Writing flag bit D6 keeps oscillator-fail
// - Low battery only on main supply, below threshold
// - Interrupt enable low disables low-battery detect
// - Time-save enable copies counters continuously
// - Battery switch clears time-save enable
// - Status flag follows failure, cleared on return
// - Lock-out gated by chip select during access
`default_nettype none
package pflc_pkg;

    // System clock rate in kHz
    localparam int unsigned SYS_KHZ = 25000;
    // Prescaled tick period in ns
    localparam int unsigned TICK_NS = 1000;
    localparam int unsigned TICK_DIV = SYS_KHZ * TICK_NS / 1000000;
    // Debounce least time in us, counted in ticks
    localparam int unsigned DEB_US = 30;
    localparam int unsigned DEB_TICKS = DEB_US * 1000 / TICK_NS;
    // Longest access hold in us
    localparam int unsigned HOLD_US = 30;
    localparam int unsigned HOLD_TICKS = HOLD_US * 1000 / TICK_NS;
    // Lock-out grace delay in us
    localparam int unsigned GRACE_US = 480;
    localparam int unsigned GRACE_TICKS = GRACE_US * 1000 / TICK_NS;
    // Width of the tick counters
    localparam int unsigned CNT_W = 10;

    // Lock-out sequencer states
    typedef enum logic [1:0] {
        PFLC_RUN   = 2'b00,
        PFLC_GRACE = 2'b01,
        PFLC_LOCK  = 2'b10,
        PFLC_RECOV = 2'b11
    } pflc_state_e;

    // Status bits presented to the register file
    typedef struct packed {
        logic power_fail_flag;  // Follows internal failure
        logic osc_fail_flag;    // Timekeeping failed
        logic low_battery;      // Battery below threshold
        logic time_save_en;     // Time-save enable state
        logic clock_start;      // Clock start bit
    } pflc_status_s;

endpackage
`default_nettype wire

// ===== rtl/pflc_tick.sv
/*
 * Prescaler: one-cycle tick enable every TICK_DIV system clocks.
 * Assumes a free-running system clock.
 */
`timescale 1ns/1ns
`default_nettype none
module pflc_tick #(
    parameter int unsigned DIV = pflc_pkg::TICK_DIV
) (
    input  wire logic clk_sys,  // System clock
    input  wire logic reset_n,  // Async reset, active low
    output logic      tick      // One-cycle tick
);
    logic [7:0] cnt_q;          // Divider count
    logic [7:0] cnt_d;          // Next count

    // Next count wraps at DIV
    always_comb begin
        if (cnt_q == 8'(DIV - 1)) begin
            cnt_d = 8'h00;
        end else begin
            cnt_d = cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign tick = (cnt_q == 8'(DIV - 1));
endmodule // pflc_tick
`default_nettype wire

// ===== rtl/pflc_sync.sv
/*
 * Three-stage synchroniser; output changes when stages 2 and 3 agree.
 * Assumes an asynchronous level input.
 */
`timescale 1ns/1ns
`default_nettype none
module pflc_sync #(
    parameter logic INIT = 1'b1
) (
    input  wire logic clk_sys,  // System clock
    input  wire logic reset_n,  // Async reset, active low
    input  wire logic din,      // Asynchronous input
    output logic      dout      // Filtered level
);
    logic [2:0] sh_q;           // Shift stages
    logic       out_q;          // Agreed level
    logic       out_d;          // Next agreed level

    // Change counts only once stages 2 and 3 agree
    always_comb begin
        out_d = out_q;
        if (sh_q[1] == sh_q[2]) begin
            out_d = sh_q[2];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sh_q  <= {3{INIT}};
            out_q <= INIT;
        end else begin
            sh_q  <= {sh_q[1:0], din};
            out_q <= out_d;
        end
    end

    assign dout = out_q;
endmodule // pflc_sync
`default_nettype wire

// ===== rtl/pflc_ctrl.sv
/*
 * Power-fail lock-out controller: debounce, grace delay, forced
 * lock-out, recovery, oscillator-fail, low-battery and time-save.
 * Assumes analog comparators and clock counters sit outside and
 * that control bits arrive as plain ports from the register file.
 */
`timescale 1ns/1ns
`default_nettype none
module pflc_ctrl #(
    parameter int unsigned CNT_DEB   = pflc_pkg::DEB_TICKS,
    parameter int unsigned CNT_HOLD  = pflc_pkg::HOLD_TICKS,
    parameter int unsigned CNT_GRACE = pflc_pkg::GRACE_TICKS
) (
    input  wire logic     clk_sys,            // 25 MHz clock
    input  wire logic     reset_n,            // Async reset
    input  wire logic     power_loss_input_n, // Power-fail pin
    input  wire logic     on_battery,         // Standby on battery
    input  wire logic     battery_low_cmp,    // Battery below 2.1V
    input  wire logic     cs_n,               // Chip select
    input  wire logic     rd_n,               // Read strobe
    input  wire logic     wr_n,               // Write strobe
    input  wire logic     delay_en,           // Lock-out delay enable
    input  wire logic     pf_int_en,          // Power-fail int enable
    input  wire logic     int_pf_oper,        // Ints run after fail
    input  wire logic     clock_start_set,    // Software start pulse
    input  wire logic     clock_start_clr,    // Software stop pulse
    input  wire logic     pflag_d6_wr,        // Write of flag bit D6
    input  wire logic     time_save_set,      // Software sets enable
    input  wire logic     time_save_clr,      // Software clears it
    output logic          bus_locked,         // Bus locked out
    output logic          bus_enable,         // Strobes honoured
    output logic          data_drive_en,      // Data bus may drive
    output logic          irq_open_drain,     // Int pins open drain
    output logic          pf_sense_on,        // Linear sensing on
    output logic          int_logic_run,      // Interrupt logic runs
    output logic          pf_irq,             // Power-fail interrupt
    output logic          time_save_copy,     // Copy counters now
    output var pflc_pkg::pflc_status_s status // Status bits
);
    // Terminal counts: the first tick after a change lands anywhere in
    // its period; only the debounce counts one tick more to stay at or
    // above its minimum; hold can end up to one tick short, while grace starts on a tick and runs its full count.
    localparam logic [9:0] DEB_M   = 10'(CNT_DEB);
    localparam logic [9:0] HOLD_M  = 10'(CNT_HOLD);
    localparam logic [9:0] GRACE_M = 10'(CNT_GRACE);

    logic tick;                 // Prescaled tick
    logic pin_n;                // Synchronised power pin
    pflc_pkg::pflc_state_e st_q, st_d;   // Sequencer state
    logic [9:0] deb_q, deb_d;   // Debounce counter
    logic [9:0] grc_q, grc_d;   // Grace counter
    logic [9:0] hld_q, hld_d;   // Access hold counter
    logic fail_q, fail_d;       // Internal power-failing
    logic osc_q, osc_d;         // Oscillator-fail flag
    logic start_q, start_d;     // Clock start bit
    logic tse_q, tse_d;         // Time-save enable
    logic lowb_q, lowb_d;       // Low-battery bit
    logic bat_q;                // Battery state last cycle
    logic access;               // Strobe active with chip select
    logic lock_now;             // Lock-out allowed this cycle

    pflc_tick u_tick (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .tick    (tick)
    );

    pflc_sync #(.INIT(1'b1)) u_sync (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .din     (power_loss_input_n),
        .dout    (pin_n)
    );

    // Only a live strobe counts as an access
    assign access = !cs_n && (!rd_n || !wr_n);

    // Lock when access ends, or it was held too long
    always_comb begin
        lock_now = !access;
        if (hld_q >= HOLD_M) begin
            lock_now = 1'b1;
        end
    end

    // Sequencer and counters next state
    always_comb begin
        st_d   = st_q;
        deb_d  = deb_q;
        grc_d  = grc_q;
        hld_d  = hld_q;
        fail_d = fail_q;
        // Hold counter runs while an access stays open after failure
        if (fail_q && access) begin
            if (tick && hld_q != HOLD_M) begin
                hld_d = hld_q + 10'h001;
            end
        end else begin
            hld_d = 10'h000;
        end
        case (st_q)
            pflc_pkg::PFLC_RUN: begin
                if (pin_n) begin
                    deb_d = 10'h000;
                end else if (tick) begin
                    if (deb_q == DEB_M) begin
                        fail_d = 1'b1;
                        deb_d  = 10'h000;
                        grc_d  = 10'h000;
                        st_d   = pflc_pkg::PFLC_GRACE;
                    end else begin
                        deb_d = deb_q + 10'h001;
                    end
                end
            end
            pflc_pkg::PFLC_GRACE: begin
                if (tick && grc_q != GRACE_M) begin
                    grc_d = grc_q + 10'h001;
                end
                if (lock_now && (!delay_en || grc_q == GRACE_M)) begin
                    st_d = pflc_pkg::PFLC_LOCK;
                end
            end
            pflc_pkg::PFLC_LOCK: begin
                if (!pin_n) begin
                    deb_d = 10'h000;
                end else if (tick) begin
                    deb_d = deb_q + 10'h001;
                    st_d  = pflc_pkg::PFLC_RECOV;
                end
            end
            pflc_pkg::PFLC_RECOV: begin
                if (!pin_n) begin
                    deb_d = 10'h000;
                    st_d  = pflc_pkg::PFLC_LOCK;
                end else if (tick) begin
                    if (deb_q == DEB_M) begin
                        fail_d = 1'b0;
                        deb_d  = 10'h000;
                        st_d   = pflc_pkg::PFLC_RUN;
                    end else begin
                        deb_d = deb_q + 10'h001;
                    end
                end
            end
            default: begin
                st_d = pflc_pkg::PFLC_RUN;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_q   <= pflc_pkg::PFLC_RUN;
            deb_q  <= 10'h000;
            grc_q  <= 10'h000;
            hld_q  <= 10'h000;
            fail_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            deb_q  <= deb_d;
            grc_q  <= grc_d;
            hld_q  <= hld_d;
            fail_q <= fail_d;
        end
    end

    // Status bits next state; set wins over software clear
    always_comb begin
        osc_d   = osc_q;
        start_d = start_q;
        tse_d   = tse_q;
        lowb_d  = 1'b0;
        if (clock_start_set) begin
            start_d = 1'b1;
            osc_d   = 1'b0;
        end else if (clock_start_clr) begin
            start_d = 1'b0;
        end
        // flag D6 write leaves flag alone
        if (pflag_d6_wr) begin
            osc_d = osc_d;
        end
        // Software may set or clear the time-save enable
        if (time_save_set) begin
            tse_d = 1'b1;
        end else if (time_save_clr) begin
            tse_d = 1'b0;
        end
        if (on_battery && !bat_q) begin
            tse_d = 1'b0;
        end
        // main supply only; gated by enable
        if (!on_battery && pf_int_en && battery_low_cmp) begin
            lowb_d = 1'b1;
        end
    end

    // Status registers; power-up values
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            osc_q   <= 1'b1;
            start_q <= 1'b0;
            tse_q   <= 1'b0;
            lowb_q  <= 1'b0;
            bat_q   <= 1'b0;
        end else begin
            osc_q   <= osc_d;
            start_q <= start_d;
            tse_q   <= tse_d;
            lowb_q  <= lowb_d;
            bat_q   <= on_battery;
        end
    end

    assign bus_locked     = (st_q == pflc_pkg::PFLC_LOCK) ||
                            (st_q == pflc_pkg::PFLC_RECOV);
    assign bus_enable     = !bus_locked;
    assign data_drive_en  = !bus_locked && !cs_n && !rd_n;
    assign irq_open_drain = bus_locked && on_battery;
    // sensing off when masked; off on battery
    assign pf_sense_on    = pf_int_en && !on_battery;
    assign int_logic_run  = !fail_q || int_pf_oper;
    assign pf_irq         = fail_q && pf_int_en;
    assign time_save_copy = tse_q;
    assign status = '{power_fail_flag: fail_q, osc_fail_flag: osc_q,
                      low_battery: lowb_q, time_save_en: tse_q,
                      clock_start: start_q};

    // Failure always begins the grace state
    property p_fail_grace;
        @(posedge clk_sys) disable iff (!reset_n)
        $rose(fail_q) |-> st_q == pflc_pkg::PFLC_GRACE;
    endproperty
    a_fail_grace: assert property (p_fail_grace)
        else $error("failure without grace state");

    // No lock during live access unless hold expired
    property p_gate_cs;
        @(posedge clk_sys) disable iff (!reset_n)
        (st_q == pflc_pkg::PFLC_GRACE && access && hld_q < HOLD_M)
        |=> st_q != pflc_pkg::PFLC_LOCK;
    endproperty
    a_gate_cs: assert property (p_gate_cs)
        else $error("locked during an access");

    // Delay disabled and no access locks next cycle
    property p_early;
        @(posedge clk_sys) disable iff (!reset_n)
        (st_q == pflc_pkg::PFLC_GRACE && !delay_en && !access)
        |=> st_q == pflc_pkg::PFLC_LOCK;
    endproperty
    a_early: assert property (p_early)
        else $error("lock not immediate");

    // Held strobe forces lock
    property p_force;
        @(posedge clk_sys) disable iff (!reset_n)
        (st_q == pflc_pkg::PFLC_GRACE && hld_q == HOLD_M && !delay_en)
        |=> bus_locked;
    endproperty
    a_force: assert property (p_force)
        else $error("forced lock missing");

    // Locked state holds while pin low
    property p_stay;
        @(posedge clk_sys) disable iff (!reset_n)
        (bus_locked && !pin_n) |=> bus_locked;
    endproperty
    a_stay: assert property (p_stay)
        else $error("unlocked while pin low");

    // Data bus never driven while locked
    property p_iso;
        @(posedge clk_sys) disable iff (!reset_n)
        bus_locked |-> !data_drive_en && !bus_enable;
    endproperty
    a_iso: assert property (p_iso)
        else $error("bus active while locked");

    // Battery switch clears time-save
    property p_tse;
        @(posedge clk_sys) disable iff (!reset_n)
        $rose(on_battery) |=> !tse_q;
    endproperty
    a_tse: assert property (p_tse)
        else $error("time save not cleared");

    // Low battery only on main supply with enable
    property p_lowb;
        @(posedge clk_sys) disable iff (!reset_n)
        lowb_q |-> !$past(on_battery) && $past(pf_int_en);
    endproperty
    a_lowb: assert property (p_lowb)
        else $error("low battery set wrongly");

    // Oscillator-fail only drops with clock start
    property p_osc;
        @(posedge clk_sys) disable iff (!reset_n)
        $fell(osc_q) |-> start_q;
    endproperty
    a_osc: assert property (p_osc)
        else $error("osc flag dropped early");
endmodule // pflc_ctrl
`default_nettype wire

// ===== testbench/pflc_host_model.sv
/*
 * Host side model: bus strobes, power pin and control bits.
 * Assumes the bench changes its requests at the falling edge.
 */
`timescale 1ns/1ns
`default_nettype none
module pflc_host_model (
    input  wire logic pin_low,            // Pull power pin low
    input  wire logic hold_rd,            // Hold one read access
    input  wire logic grace_req,          // Ask for lock-out delay
    input  wire logic int_req,            // Ask for fail interrupt
    input  wire logic single,             // Single-supply setup
    output logic      power_loss_input_n, // Power pin
    output logic      cs_n,               // Chip select
    output logic      rd_n,               // Read strobe
    output logic      wr_n,               // Write strobe
    output logic      delay_en,           // Delay enable bit
    output logic      pf_int_en           // Interrupt enable bit
);
    // Pin follows the supply request
    assign power_loss_input_n = !pin_low;
    // Access is one unbroken strobe, so a stuck cycle can be modelled
    assign cs_n = !hold_rd;
    assign rd_n = !hold_rd;
    // Writes are never issued by this model
    assign wr_n = 1'b1;
    assign delay_en = grace_req;
    assign pf_int_en = int_req && !single;
endmodule // pflc_host_model
`default_nettype wire

// ===== testbench/power_fail_lockout_control_tb.sv
/*
 * Self-checking bench for the power-fail lock-out controller.
 * Assumes a 25-clock tick and shortened count parameters.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    bad_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end end
module power_fail_lockout_control_tb;
    localparam int DEB = 6;   // Debounce ticks
    localparam int HOLD = 8;  // Access hold ticks
    localparam int GRC = 20;  // Grace ticks
    localparam int TK = 25;   // Clocks per tick
    logic clk_sys = 1'b0;     // System clock
    logic reset_n = 1'b0;     // Reset, active low
    logic pin_low = 1'b0, hold_rd = 1'b0, grace_req = 1'b0;
    logic int_req = 1'b1, single = 1'b0;
    logic on_battery = 1'b0, battery_low_cmp = 1'b0;
    logic int_pf_oper = 1'b0, clock_start_set = 1'b0;
    logic clock_start_clr = 1'b0, pflag_d6_wr = 1'b0;
    logic time_save_set = 1'b0, time_save_clr = 1'b0;
    wire logic pin_n, cs_n, rd_n, wr_n, delay_en, pf_int_en;
    logic bus_locked, bus_enable, data_drive_en, irq_open_drain;
    logic pf_sense_on, int_logic_run, pf_irq, time_save_copy;
    pflc_pkg::pflc_status_s st;  // Status bits
    int bad_count = 0;           // Mismatches
    int n_tests = 0;             // Comparisons

    // Clock at 25 MHz
    always #20 clk_sys = ~clk_sys;

    pflc_host_model u_host (
        .pin_low(pin_low), .hold_rd(hold_rd), .grace_req(grace_req),
        .int_req(int_req), .single(single),
        .power_loss_input_n(pin_n), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .delay_en(delay_en), .pf_int_en(pf_int_en));

    pflc_ctrl #(.CNT_DEB(DEB), .CNT_HOLD(HOLD), .CNT_GRACE(GRC)) u_dut (
        .clk_sys(clk_sys), .reset_n(reset_n),
        .power_loss_input_n(pin_n), .on_battery(on_battery),
        .battery_low_cmp(battery_low_cmp), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .delay_en(delay_en), .pf_int_en(pf_int_en),
        .int_pf_oper(int_pf_oper), .clock_start_set(clock_start_set),
        .clock_start_clr(clock_start_clr), .pflag_d6_wr(pflag_d6_wr),
        .time_save_set(time_save_set), .time_save_clr(time_save_clr),
        .bus_locked(bus_locked), .bus_enable(bus_enable),
        .data_drive_en(data_drive_en), .irq_open_drain(irq_open_drain),
        .pf_sense_on(pf_sense_on), .int_logic_run(int_logic_run),
        .pf_irq(pf_irq), .time_save_copy(time_save_copy), .status(st));

    // Wait whole cycles, landing on the falling edge
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Pull the pin low and wait, bounded, for the failure flag
    task automatic fail_now();
        int k;
        pin_low = 1'b1;
        cyc(DEB * TK);
        `CHK("early_fail", 1'b0, st.power_fail_flag)
        k = 0;
        while (st.power_fail_flag !== 1'b1 && k < 3 * TK) begin
            cyc(1);
            k++;
        end
        `CHK("fail_flag", 1'b1, st.power_fail_flag)
    endtask

    // Release the pin; lock must hold through one debounce span
    task automatic restore();
        pin_low = 1'b0;
        cyc(DEB * TK);
        `CHK("hold_lock", 1'b1, bus_locked)
        cyc(TK + 6);
        `CHK("unlock", 1'b0, bus_locked)
        `CHK("flag_clr", 1'b0, st.power_fail_flag)
    endtask

    // One line as each test ends
    task automatic done(input string nm);
        $display("test %s done", nm);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog: the tests need well under 6000 clocks
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        summarize();
    end

    // Main sequence
    initial begin
        cyc(12);
        reset_n = 1'b1;
        cyc(2);
        `CHK("osc_fail", 1'b1, st.osc_fail_flag)
        `CHK("clk_start", 1'b0, st.clock_start)
        `CHK("locked", 1'b0, bus_locked)
        done("reset");
        // Flag write must not disturb the oscillator-fail flag
        pflag_d6_wr = 1'b1;
        cyc(1);
        pflag_d6_wr = 1'b0;
        cyc(2);
        `CHK("osc_keep", 1'b1, st.osc_fail_flag)
        clock_start_set = 1'b1;
        cyc(1);
        clock_start_set = 1'b0;
        cyc(2);
        `CHK("osc_clr", 1'b0, st.osc_fail_flag)
        `CHK("started", 1'b1, st.clock_start)
        clock_start_clr = 1'b1;
        cyc(1);
        clock_start_clr = 1'b0;
        cyc(2);
        `CHK("stopped", 1'b0, st.clock_start)
        `CHK("osc_stays", 1'b0, st.osc_fail_flag)
        done("osc");
        // Short low pulse is noise
        pin_low = 1'b1;
        cyc((DEB - 2) * TK);
        pin_low = 1'b0;
        cyc(3 * TK);
        `CHK("noise", 1'b0, st.power_fail_flag)
        done("noise");
        // Plain failure, no delay, no access
        battery_low_cmp = 1'b1;
        cyc(3);
        `CHK("lowbat", 1'b1, st.low_battery)
        `CHK("sense", 1'b1, pf_sense_on)
        fail_now();
        `CHK("irq", 1'b1, pf_irq)
        `CHK("int_stop", 1'b0, int_logic_run)
        cyc(2);
        `CHK("lock", 1'b1, bus_locked)
        `CHK("bus_en", 1'b0, bus_enable)
        hold_rd = 1'b1;
        int_pf_oper = 1'b1;
        cyc(1);
        `CHK("no_drive", 1'b0, data_drive_en)
        `CHK("int_run", 1'b1, int_logic_run)
        `CHK("od_main", 1'b0, irq_open_drain)
        hold_rd = 1'b0;
        restore();
        done("fail");
        // Full grace delay, then grace cut short by the host
        grace_req = 1'b1;
        fail_now();
        cyc(GRC * TK - 10);
        `CHK("grace_open", 1'b0, bus_locked)
        cyc(2 * TK);
        `CHK("grace_lock", 1'b1, bus_locked)
        restore();
        fail_now();
        cyc(5 * TK);
        `CHK("cut_open", 1'b0, bus_locked)
        grace_req = 1'b0;
        cyc(2);
        `CHK("cut_lock", 1'b1, bus_locked)
        restore();
        done("grace");
        // Access stuck across the failure
        hold_rd = 1'b1;
        cyc(2);
        `CHK("drive", 1'b1, data_drive_en)
        fail_now();
        cyc(2);
        `CHK("cs_gate", 1'b0, bus_locked)
        cyc((HOLD - 3) * TK);
        `CHK("hold_open", 1'b0, bus_locked)
        cyc(3 * TK);
        `CHK("forced", 1'b1, bus_locked)
        hold_rd = 1'b0;
        restore();
        done("hold");
        // Single supply: interrupt masked, lock-out still acts
        single = 1'b1;
        cyc(3);
        `CHK("sense_off", 1'b0, pf_sense_on)
        `CHK("lowbat_off", 1'b0, st.low_battery)
        fail_now();
        `CHK("no_irq", 1'b0, pf_irq)
        cyc(2);
        `CHK("m_lock", 1'b1, bus_locked)
        restore();
        single = 1'b0;
        done("masked");
        // Time save frozen by software clear or the battery switch, not by failure
        time_save_set = 1'b1;
        cyc(1);
        time_save_set = 1'b0;
        cyc(2);
        `CHK("ts_on", 1'b1, time_save_copy)
        // Software clear, then set and clear together: set wins
        time_save_clr = 1'b1;
        cyc(1);
        time_save_clr = 1'b0;
        cyc(2);
        `CHK("ts_sw_off", 1'b0, st.time_save_en)
        time_save_set = 1'b1;
        time_save_clr = 1'b1;
        cyc(1);
        time_save_set = 1'b0;
        time_save_clr = 1'b0;
        cyc(2);
        `CHK("ts_both", 1'b1, time_save_copy)
        fail_now();
        cyc(2);
        `CHK("ts_pin", 1'b1, time_save_copy)
        on_battery = 1'b1;
        cyc(3);
        `CHK("ts_off", 1'b0, st.time_save_en)
        `CHK("od_bat", 1'b1, irq_open_drain)
        `CHK("sense_bat", 1'b0, pf_sense_on)
        `CHK("lowbat_bat", 1'b0, st.low_battery)
        on_battery = 1'b0;
        restore();
        done("battery");
        summarize();
    end
endmodule // power_fail_lockout_control_tb
`default_nettype wire
